// ### nfh_host.sv
// Host controller driving the NAND flash pins, one strobe pulse per request
`timescale 1ns/1ns
// Overview of operation
// - One shared I/O bus carries commands, addresses, write data and read data.
// - Commands and addresses use low eight lines; upper lines carry data only.
// - Command latch high: device takes bus as command on write strobe rise.
// - Address latch high: device takes bus as address on write strobe rise.
module nfh_host #(
  parameter int unsigned DATA_W = 16
) (
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic              reqValid,
  output logic                   reqReady,
  input  wire logic [1:0]        reqKind,
  input  wire logic [DATA_W-1:0] reqData,
  input  wire logic              reqLast,
  output logic                   rspValid,
  input  wire logic              rspReady,
  output logic [DATA_W-1:0]      rspData,
  input  wire logic              writeProtectN,
  input  wire logic              lockEnable,
  output logic                   flashBusy,
  output logic                   cmdLatch,
  output logic                   addrLatch,
  output logic                   chipSelectN,
  output logic                   writeStrobeN,
  output logic                   output_strobe_n,
  output logic                   writeProtN,
  output logic                   lock_autoload_en,
  input  wire logic [DATA_W-1:0] ioIn,
  output logic [DATA_W-1:0]      ioOut,
  output logic                   ioOe,
  input  wire logic              readyBusyIn
);
  nfh_pkg::nfh_state_e stateReg, stateNext;
  logic [nfh_pkg::CNT_W-1:0] cntReg;
  logic [1:0]        kindReg;
  logic              lastReg;
  logic [DATA_W-1:0] capReg;
  logic [2:0]        rbSync;
  logic              rbReg;
  logic [DATA_W-1:0] bufData [2];
  logic [1:0]        bufValid;
  logic              wrPtr, rdPtr;
  logic [1:0]        bufCount;

  // Ready/busy pin through three flops; accept change when last two agree
  wire rbStable = (rbSync[1] == rbSync[2]);
  wire bufFull  = (bufCount == 2'h2);
  wire isRead   = (kindReg == nfh_pkg::KIND_RD);
  wire reqRead  = (reqKind == nfh_pkg::KIND_RD);
  wire lowDone  = (cntReg == nfh_pkg::CNT_W'(nfh_pkg::STROBE_LOW_CYC - 1));
  wire highDone = (cntReg == nfh_pkg::CNT_W'(nfh_pkg::STROBE_HIGH_CYC - 1));
  wire startOk  = (stateReg == nfh_pkg::ST_IDLE) && reqValid && rbReg
               && !(reqRead && bufFull);
  wire pushBuf  = (stateReg == nfh_pkg::ST_PUSH) && !bufFull;
  wire popBuf   = rspValid && rspReady;
  // Command and address bytes use only the low eight lines
  wire [DATA_W-1:0] outWord = (reqKind == nfh_pkg::KIND_WR) ? reqData
                            : {{(DATA_W-8){1'b0}}, reqData[7:0]};

  always_comb begin
    stateNext = stateReg;
    case (stateReg)
      nfh_pkg::ST_IDLE: if (startOk) stateNext = nfh_pkg::ST_LOW;
      nfh_pkg::ST_LOW:  if (lowDone) stateNext = nfh_pkg::ST_HIGH;
      nfh_pkg::ST_HIGH:
        if (highDone)
          stateNext = isRead ? nfh_pkg::ST_PUSH : nfh_pkg::ST_DONE;
      nfh_pkg::ST_PUSH: if (!bufFull) stateNext = nfh_pkg::ST_DONE;
      nfh_pkg::ST_DONE: stateNext = nfh_pkg::ST_IDLE;
      default:          stateNext = nfh_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rbSync <= 3'h0;
      rbReg  <= 1'b0;
    end else begin
      rbSync <= {rbSync[1:0], readyBusyIn};
      if (rbStable) rbReg <= rbSync[2];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      stateReg <= nfh_pkg::ST_IDLE;
      cntReg   <= '0;
    end else begin
      stateReg <= stateNext;
      cntReg   <= (stateNext != stateReg) ? '0 : cntReg + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      kindReg      <= nfh_pkg::KIND_CMD;
      lastReg      <= 1'b1;
      cmdLatch     <= 1'b0;
      addrLatch    <= 1'b0;
      chipSelectN  <= 1'b1;
      writeStrobeN <= 1'b1;
      output_strobe_n <= 1'b1;
      ioOut        <= '0;
      ioOe         <= 1'b0;
      reqReady     <= 1'b0;
      capReg       <= '0;
    end else begin
      reqReady <= startOk;
      if (startOk) begin
        kindReg     <= reqKind;
        lastReg     <= reqLast;
        chipSelectN <= 1'b0;
        cmdLatch    <= (reqKind == nfh_pkg::KIND_CMD);
        addrLatch   <= (reqKind == nfh_pkg::KIND_ADDR);
        ioOut       <= outWord;
        ioOe        <= (reqKind != nfh_pkg::KIND_RD);
        writeStrobeN    <= (reqKind == nfh_pkg::KIND_RD);
        output_strobe_n <= (reqKind != nfh_pkg::KIND_RD);
      end
      if (stateReg == nfh_pkg::ST_LOW && lowDone) begin
        // Rising write or read strobe edge while bus and latches stay put
        writeStrobeN    <= 1'b1;
        output_strobe_n <= 1'b1;
        if (isRead) capReg <= ioIn;
      end
      if (stateReg == nfh_pkg::ST_DONE) begin
        cmdLatch  <= 1'b0;
        addrLatch <= 1'b0;
        ioOe      <= 1'b0;
        if (lastReg) chipSelectN <= 1'b1;
      end
    end
  end

  // Two-entry buffer for read words so a stalled consumer loses none
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr    <= 1'b0;
      rdPtr    <= 1'b0;
      bufCount <= 2'h0;
      rspValid <= 1'b0;
      rspData  <= '0;
      bufValid <= 2'h0;
    end else begin
      if (pushBuf) begin
        wrPtr <= ~wrPtr;
        bufValid[wrPtr] <= 1'b1;
      end
      if (popBuf) begin
        rdPtr <= ~rdPtr;
        bufValid[rdPtr] <= 1'b0;
      end
      bufCount <= bufCount + {1'b0, pushBuf} - {1'b0, popBuf};
      rspValid <= (bufCount + {1'b0, pushBuf} - {1'b0, popBuf}) != 2'h0;
      rspData  <= popBuf ? bufData[~rdPtr] : bufData[rdPtr];
      if (!rspValid || popBuf) begin
        if (popBuf && bufCount == 2'h1 || bufCount == 2'h0)
          rspData <= capReg;
      end
    end
  end

  genvar gi;
  for (gi = 0; gi < 2; gi++) begin : g_buf
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) bufData[gi] <= '0;
      else if (pushBuf && wrPtr == 1'(gi)) bufData[gi] <= capReg;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      writeProtN       <= 1'b0;
      lock_autoload_en <= 1'b0;
      flashBusy        <= 1'b1;
    end else begin
      writeProtN       <= writeProtectN;
      lock_autoload_en <= lockEnable;
      flashBusy        <= !rbReg;
    end
  end

  no_both_latch_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !(cmdLatch && addrLatch)) else $error("both latches high");
  select_held_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!writeStrobeN) |-> !chipSelectN) else $error("strobe deselected");
  // Write strobe returning high, and a full-width low pulse before it
  sequence writeRiseSeq;
    !writeStrobeN ##1 writeStrobeN;
  endsequence
  sequence strobeHeldSeq;
    (!writeStrobeN)[*2] ##1 writeStrobeN;
  endsequence
  bus_stable_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    writeRiseSeq |-> $stable(ioOut) && ioOe)
    else $error("bus moved at rise");
  read_float_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!output_strobe_n) |-> !ioOe) else $error("drive during read");
  strobe_len_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    $fell(writeStrobeN) |-> strobeHeldSeq)
    else $error("write strobe width");
  byte_lanes_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (cmdLatch || addrLatch) |-> ioOut[DATA_W-1:8] == '0)
    else $error("upper lines used");
  busy_wait_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(reqReady) |-> $past(rbReg)) else $error("start while busy");
  buf_bound_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    bufCount <= 2'h2) else $error("buffer overrun");
  buf_valid_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    rspValid == (bufValid != 2'h0)) else $error("buffer flags");
endmodule : nfh_host

// ### nfh_pkg.sv
// Package for the host-side NAND flash pin controller
package nfh_pkg;
  localparam int unsigned CLK_MHZ        = 20;
  localparam int unsigned STROBE_LOW_NS  = 100;
  localparam int unsigned STROBE_HIGH_NS = 100;
  localparam int unsigned STROBE_LOW_CYC =
    (STROBE_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned STROBE_HIGH_CYC =
    (STROBE_HIGH_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W = 4;
  localparam logic [1:0] KIND_CMD  = 2'h0;
  localparam logic [1:0] KIND_ADDR = 2'h1;
  localparam logic [1:0] KIND_WR   = 2'h2;
  localparam logic [1:0] KIND_RD   = 2'h3;
  localparam logic [7:0] CMD_READ_LOW  = 8'h00;
  localparam logic [7:0] CMD_READ_HIGH = 8'h01;
  localparam int unsigned ADDR_CYCLES = 3;
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_LOW   = 5'h02,
    ST_HIGH  = 5'h04,
    ST_PUSH  = 5'h08,
    ST_DONE  = 5'h10
  } nfh_state_e;
endpackage : nfh_pkg

// ### nfh_flash_model.sv
// Behavioural flash device seen through its pins
`timescale 1ns/1ns
module nfh_flash_model (
  input  wire logic        cmdLatch,
  input  wire logic        addrLatch,
  input  wire logic        chipSelectN,
  input  wire logic        writeStrobeN,
  input  wire logic        output_strobe_n,
  input  wire logic        writeProtN,
  input  wire logic        ioOe,
  input  wire logic [15:0] ioOut,
  output logic      [15:0] ioIn,
  output logic             readyBusyIn
);
  logic [7:0]  lastCmd = 8'h00;
  logic [8:0]  col = 9'h000;
  logic [15:0] rdData = 16'h0000;
  int          addrCount = 0;
  initial readyBusyIn = 1'b1;
  always @(posedge writeStrobeN) if (!chipSelectN) begin
    if (cmdLatch) begin
      lastCmd = ioOut[7:0];
      addrCount = 0;
      col[8] = ioOut[0];
      if (ioOut[7:0] == 8'h10 && writeProtN) begin
        readyBusyIn = 1'b0;
        readyBusyIn <= #2000 1'b1;
      end
    end else if (addrLatch) begin
      if (addrCount == 0) col[7:0] = ioOut[7:0];
      addrCount++;
    end
  end
  always @(negedge output_strobe_n) if (!chipSelectN) begin
    rdData = {~col[7:0], col[7:0]};
    col = col + 9'h001;
  end
  // Floating bus shows the inverse of the last word
  assign ioIn = ioOe ? ioOut : (!chipSelectN && !output_strobe_n) ?
                rdData : ~rdData;
endmodule : nfh_flash_model

// ### nand_flash_pin_interface_bench.sv
// Self-checking bench for the host flash pin controller
`timescale 1ns/1ns
module nand_flash_pin_interface_bench;
  logic        sys_clk = 0, resetn = 0, reqValid = 0, reqLast = 0;
  logic        rspReady = 0, writeProtectN = 1, lockEnable = 0;
  logic [1:0]  reqKind = 2'h0;
  logic [15:0] reqData = 16'h0000, ioIn, ioOut, rspData;
  logic        reqReady, rspValid, flashBusy, cmdLatch, addrLatch, ioOe;
  logic        chipSelectN, writeStrobeN, output_strobe_n, writeProtN;
  logic        lock_autoload_en, readyBusyIn;
  logic [15:0] expQ[$];
  logic [8:0]  c;
  logic [7:0]  a;
  int          fail_count = 0, comparisons = 0, seed = 32'h1ac0b442;
  always #25 sys_clk = ~sys_clk;
  nfh_host i_dut (.sys_clk(sys_clk), .resetn(resetn), .reqValid(reqValid),
    .reqReady(reqReady), .reqKind(reqKind), .reqData(reqData),
    .reqLast(reqLast), .rspValid(rspValid), .rspReady(rspReady),
    .rspData(rspData), .writeProtectN(writeProtectN),
    .lockEnable(lockEnable), .flashBusy(flashBusy), .cmdLatch(cmdLatch),
    .addrLatch(addrLatch), .chipSelectN(chipSelectN),
    .writeStrobeN(writeStrobeN), .output_strobe_n(output_strobe_n),
    .writeProtN(writeProtN), .lock_autoload_en(lock_autoload_en),
    .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe), .readyBusyIn(readyBusyIn));
  nfh_flash_model i_flash (.cmdLatch(cmdLatch), .addrLatch(addrLatch),
    .chipSelectN(chipSelectN), .writeStrobeN(writeStrobeN),
    .output_strobe_n(output_strobe_n), .writeProtN(writeProtN),
    .ioOe(ioOe), .ioOut(ioOut), .ioIn(ioIn), .readyBusyIn(readyBusyIn));
  task chk(input bit ok);
    comparisons++;
    if (!ok) begin
      fail_count++;
      $display("unexpected at %0t ns: value mismatch", $time);
    end
  endtask : chk
  task send(input logic [1:0] k, input logic [15:0] d, input logic l);
    int n;
    n = 0;
    @(posedge sys_clk);
    reqValid <= 1'b1;
    reqKind <= k;
    reqData <= d;
    reqLast <= l;
    do @(posedge sys_clk); while (reqReady !== 1'b1 && ++n < 200);
    chk(n < 200);
    reqValid <= 1'b0;
  endtask : send
  task complete_run;
    if (fail_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  // Random stalls by the receiver fill the read buffer
  always @(posedge sys_clk) begin
    rspReady <= 1'($random(seed));
    if (rspValid === 1'b1 && rspReady === 1'b1)
      chk(expQ.size() > 0 && rspData === expQ.pop_front());
  end
  initial begin
    #2000000;
    fail_count++;
    complete_run;
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    for (int h = 0; h < 2; h++) begin
      a = $random(seed);
      send(nfh_pkg::KIND_CMD, h, 1'b0);
      // Fourth address byte must be ignored
      for (int i = 0; i < 4; i++)
        send(nfh_pkg::KIND_ADDR, i ? $random(seed) & 16'h00FF : a,
             1'b0);
      c = {h[0], a};
      chk(i_flash.lastCmd === h && i_flash.col === c);
      for (int i = 0; i < 6; i++) begin
        expQ.push_back({~c[7:0], c[7:0]});
        c++;
        send(nfh_pkg::KIND_RD, 16'h0000, i == 5);
      end
    end
    for (int w = 1; w >= 0; w--) begin
      writeProtectN <= w[0];
      lockEnable <= w[0];
      send(nfh_pkg::KIND_CMD, 16'h0080, 1'b0);
      for (int i = 0; i < 3; i++)
        send(nfh_pkg::KIND_ADDR, 16'h0000, 1'b0);
      send(nfh_pkg::KIND_WR, $random(seed), 1'b0);
      send(nfh_pkg::KIND_CMD, 16'h0010, 1'b1);
      repeat (10) @(posedge sys_clk);
      chk(flashBusy === w && writeProtN === w);
      chk(lock_autoload_en === w);
      // Held off while the device is busy, then accepted once it is ready
      send(nfh_pkg::KIND_CMD, 16'h0070, 1'b1);
      chk(readyBusyIn === 1'b1);
    end
    repeat (50) @(posedge sys_clk);
    chk(expQ.size() == 0);
    complete_run;
  end
endmodule : nand_flash_pin_interface_bench
